// ### common/pmb_pkg.sv
// shared constants, register map and carrier types for the mirror and storm block
package pmb_pkg;
	localparam int NUM_PORTS = 26;
	localparam int PORT_W = 5;
	localparam int LIMIT_W = 24;
	localparam int CNT_W = 32;
	localparam int TAG_W = 16;
	localparam int FIFO_DEPTH = 32;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	localparam logic [PORT_W-1:0] PORT_FIRST = 5'h01;
	localparam logic [PORT_W-1:0] PORT_LAST = 5'h1A;

	// time base
	localparam longint ONE_SECOND_NS = 64'd1000000000;
	localparam longint CLOCK_PERIOD_NS = 64'd8;
	localparam int SECOND_CYCLES = int'(ONE_SECOND_NS / CLOCK_PERIOD_NS);

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_PAIR = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_BADCFG = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_SELECT = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_LIMIT = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_RXCOUNT = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_MAXRATE = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_MAXAGE = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_CLRMAX = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_MIRMAP = 8'h24;

	// field positions
	localparam int CTRL_SAVE_BIT = 0;
	localparam int PAIR_SRC_LSB = 0;
	localparam int PAIR_DST_LSB = 8;
	localparam int PAIR_ADD_BIT = 16;
	localparam int CLR_PORT_LSB = 0;

	// reset values
	localparam logic [LIMIT_W-1:0] LIMIT_RESET = 24'hFFFFFF;
	localparam logic [CNT_W-1:0] AGE_MAX = 32'hFFFFFFFF;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [TAG_W-1:0] tag;
		logic [PORT_W-1:0] srcPort;
		logic isBcast;
		logic isErr;
	} pmb_frame_type;

	typedef struct packed {
		logic [TAG_W-1:0] tag;
		logic [PORT_W-1:0] srcPort;
		logic drop;
		logic [NUM_PORTS-1:0] mirrorMask;
	} pmb_fwd_type;
endpackage

// ### rtl/pmb_fifo.sv
// parameterised valid/ready fifo
`timescale 1ns/1ps
`default_nettype none
module pmb_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// fill side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// drain side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int PTR_W = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W:0] wrPtr;
	logic [PTR_W:0] rdPtr;
	logic push;
	logic pop;

	// extra pointer bit tells full from empty
	assign inReady = (wrPtr[PTR_W] == rdPtr[PTR_W]) || (wrPtr[PTR_W-1:0] != rdPtr[PTR_W-1:0]);
	assign outValid = wrPtr != rdPtr;
	assign push = inValid && inReady;
	assign pop = outValid && outReady;
	assign outData = mem[rdPtr[PTR_W-1:0]];

	always_ff @(posedge clock) begin
		if (push) begin
			mem[wrPtr[PTR_W-1:0]] <= inData;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			wrPtr <= '0;
			rdPtr <= '0;
		end else begin
			if (push) begin
				wrPtr <= wrPtr + 1'b1;
			end
			if (pop) begin
				rdPtr <= rdPtr + 1'b1;
			end
		end
	end
endmodule // pmb_fifo
`default_nettype wire

// ### rtl/pmb_storm_port.sv
// per-port broadcast counter, peak record and limiter
`timescale 1ns/1ps
`default_nettype none
module pmb_storm_port (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// events
	input wire logic tick,
	input wire logic bcastHit,
	input wire logic clearMax,
	input wire logic [pmb_pkg::LIMIT_W-1:0] limit,
	// state
	output logic overLimit,
	output logic [pmb_pkg::CNT_W-1:0] rxCount,
	output logic [pmb_pkg::CNT_W-1:0] maxRate,
	output logic [pmb_pkg::CNT_W-1:0] maxAge
);
	logic [pmb_pkg::CNT_W-1:0] secCount;
	logic [pmb_pkg::LIMIT_W-1:0] activeLimit;
	logic [pmb_pkg::CNT_W-1:0] closedCount;

	// a hit on the tick cycle belongs to the new second
	assign closedCount = secCount;
	// a frame on the tick cycle is the first of the new second, judged by the new limit
	assign overLimit = tick ? (limit == '0)
		: (secCount >= {{(pmb_pkg::CNT_W-pmb_pkg::LIMIT_W){1'b0}}, activeLimit});

	always_ff @(posedge clock) begin
		if (reset) begin
			rxCount <= '0;
		end else if (bcastHit) begin
			rxCount <= rxCount + 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			secCount <= '0;
		end else if (tick) begin
			secCount <= bcastHit ? 32'h00000001 : '0;
		end else if (bcastHit) begin
			secCount <= secCount + 1'b1;
		end
	end

	// limit is taken at the second boundary so a second never sees two limits
	always_ff @(posedge clock) begin
		if (reset) begin
			activeLimit <= pmb_pkg::LIMIT_RESET;
		end else if (tick) begin
			activeLimit <= limit;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			maxRate <= '0;
			maxAge <= '0;
		end else if (tick && (clearMax || closedCount > maxRate)) begin
			maxRate <= closedCount;
			maxAge <= '0;
		end else if (clearMax) begin
			maxRate <= '0;
			maxAge <= '0;
		end else if (tick && maxAge != pmb_pkg::AGE_MAX) begin
			maxAge <= maxAge + 1'b1;
		end
	end
endmodule // pmb_storm_port
`default_nettype wire

// ### rtl/pmb_mirror_storm.sv
// port mirroring and broadcast storm control with an axi4-lite register slave
//
// Behaviour
// - any of ports 1 to 26 may be mirror source, destination, or both.
// - one source may map to many destinations; each gets every copy.
// - a source port may also be a destination of other sources.
// - every frame still goes down the normal path unchanged.
// - errored frames are mirrored only when the source's bad-frame option is on.
// - software adds or deletes single source/destination pairings.
// - broadcasts beyond the port's per-second limit are dropped.
// - each port holds its own broadcast-per-second limit.
// - each port counts every received broadcast.
// - each port records its highest broadcasts in one second.
// - each port tracks seconds since that peak was reached.
// - clearing the peak also restarts its age.
`timescale 1ns/1ps
`default_nettype none
module pmb_mirror_storm #(
	parameter int TICK_CYCLES = pmb_pkg::SECOND_CYCLES
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// ingress frame descriptors
	input wire logic inValid,
	output logic inReady,
	input wire pmb_pkg::pmb_frame_type inFrame,
	// forwarding descriptors with mirror mask
	output logic fwdValid,
	input wire logic fwdReady,
	output pmb_pkg::pmb_fwd_type fwdFrame,
	// axi4-lite write address and data
	input wire logic [pmb_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [pmb_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [pmb_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [pmb_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	localparam int NP = pmb_pkg::NUM_PORTS;
	localparam int PW = pmb_pkg::PORT_W;
	localparam int LW = pmb_pkg::LIMIT_W;
	localparam int CW = pmb_pkg::CNT_W;

	// staged and committed configuration
	logic [NP-1:0] stageMap [NP];
	logic [NP-1:0] activeMap [NP];
	logic [NP-1:0] stageBad;
	logic [NP-1:0] activeBad;
	logic [LW-1:0] stageLimit [NP];
	logic [LW-1:0] activeLimit [NP];
	logic [PW-1:0] selPort;

	// per-port state
	logic [NP-1:0] overLimit;
	logic [NP-1:0] bcastHit;
	logic [NP-1:0] clearMax;
	logic [CW-1:0] rxCount [NP];
	logic [CW-1:0] maxRate [NP];
	logic [CW-1:0] maxAge [NP];

	// one-second time base
	logic [31:0] tickCount;
	logic tick;

	always_ff @(posedge clock) begin
		if (reset) begin
			tickCount <= '0;
		end else if (tick) begin
			tickCount <= '0;
		end else begin
			tickCount <= tickCount + 1'b1;
		end
	end
	assign tick = tickCount == 32'(TICK_CYCLES - 1);

	// bus write decode
	logic wrEn;
	logic [pmb_pkg::DATA_W-1:0] strbMask;
	logic [pmb_pkg::DATA_W-1:0] wrData;
	logic saveNow;
	logic pairWrite;
	logic [PW-1:0] pairSrc;
	logic [PW-1:0] pairDst;
	logic pairAdd;
	logic pairOk;
	logic selOk;
	logic [PW-1:0] selIdx;
	logic [PW-1:0] clrPort;
	logic [PW-1:0] pairSrcIdx;
	logic [PW-1:0] pairDstIdx;
	logic wrMapped;

	genvar gb;
	generate
		for (gb = 0; gb < 4; gb++) begin : gStrb
			assign strbMask[gb*8 +: 8] = {8{s_axi_wstrb[gb]}};
		end
	endgenerate

	// address and data are taken together, so arrival order does not matter
	assign wrEn = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = wrEn;
	assign s_axi_wready = wrEn;
	assign wrData = s_axi_wdata & strbMask;

	assign saveNow = wrEn && s_axi_awaddr == pmb_pkg::OFS_CTRL && wrData[pmb_pkg::CTRL_SAVE_BIT];
	assign pairWrite = wrEn && s_axi_awaddr == pmb_pkg::OFS_PAIR;
	assign pairSrc = wrData[pmb_pkg::PAIR_SRC_LSB +: PW];
	assign pairDst = wrData[pmb_pkg::PAIR_DST_LSB +: PW];
	assign pairAdd = wrData[pmb_pkg::PAIR_ADD_BIT];
	assign pairSrcIdx = pairSrc - pmb_pkg::PORT_FIRST;
	assign pairDstIdx = pairDst - pmb_pkg::PORT_FIRST;
	// a port never mirrors onto itself
	assign pairOk = pairSrc >= pmb_pkg::PORT_FIRST && pairSrc <= pmb_pkg::PORT_LAST
		&& pairDst >= pmb_pkg::PORT_FIRST && pairDst <= pmb_pkg::PORT_LAST
		&& pairSrc != pairDst;
	assign selOk = selPort >= pmb_pkg::PORT_FIRST && selPort <= pmb_pkg::PORT_LAST;
	assign selIdx = selPort - pmb_pkg::PORT_FIRST;
	assign clrPort = wrData[pmb_pkg::CLR_PORT_LSB +: PW];

	always_comb begin
		unique case (s_axi_awaddr)
			pmb_pkg::OFS_CTRL, pmb_pkg::OFS_PAIR, pmb_pkg::OFS_BADCFG, pmb_pkg::OFS_SELECT,
			pmb_pkg::OFS_LIMIT, pmb_pkg::OFS_CLRMAX: wrMapped = 1'b1;
			default: wrMapped = 1'b0;
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= pmb_pkg::RESP_OKAY;
		end else if (wrEn) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wrMapped ? pmb_pkg::RESP_OKAY : pmb_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			selPort <= pmb_pkg::PORT_FIRST;
		end else if (wrEn && s_axi_awaddr == pmb_pkg::OFS_SELECT) begin
			selPort <= (selPort & ~strbMask[PW-1:0]) | wrData[PW-1:0];
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			stageBad <= '0;
		end else if (wrEn && s_axi_awaddr == pmb_pkg::OFS_BADCFG) begin
			stageBad <= (stageBad & ~strbMask[NP-1:0]) | wrData[NP-1:0];
		end
	end

	// staged edits, then one commit copies everything over
	genvar gp;
	generate
		for (gp = 0; gp < NP; gp++) begin : gPort
			always_ff @(posedge clock) begin
				if (reset) begin
					stageMap[gp] <= '0;
				end else if (pairWrite && pairOk && pairSrcIdx == PW'(gp)) begin
					stageMap[gp][pairDstIdx] <= pairAdd;
				end
			end

			always_ff @(posedge clock) begin
				if (reset) begin
					stageLimit[gp] <= pmb_pkg::LIMIT_RESET;
				end else if (wrEn && s_axi_awaddr == pmb_pkg::OFS_LIMIT && selOk
						&& selIdx == PW'(gp)) begin
					// multiples of ten are up to software; any value is held as written
					stageLimit[gp] <= (stageLimit[gp] & ~strbMask[LW-1:0])
						| wrData[LW-1:0];
				end
			end

			always_ff @(posedge clock) begin
				if (reset) begin
					activeMap[gp] <= '0;
					activeLimit[gp] <= pmb_pkg::LIMIT_RESET;
				end else if (saveNow) begin
					activeMap[gp] <= stageMap[gp];
					activeLimit[gp] <= stageLimit[gp];
				end
			end

			assign clearMax[gp] = wrEn && s_axi_awaddr == pmb_pkg::OFS_CLRMAX
				&& clrPort == PW'(gp + 1);

			pmb_storm_port uStorm (
				.clock(clock),
				.reset(reset),
				.tick(tick),
				.bcastHit(bcastHit[gp]),
				.clearMax(clearMax[gp]),
				.limit(activeLimit[gp]),
				.overLimit(overLimit[gp]),
				.rxCount(rxCount[gp]),
				.maxRate(maxRate[gp]),
				.maxAge(maxAge[gp])
			);
		end
	endgenerate

	always_ff @(posedge clock) begin
		if (reset) begin
			activeBad <= '0;
		end else if (saveNow) begin
			activeBad <= stageBad;
		end
	end

	// bus read
	logic [pmb_pkg::DATA_W-1:0] rdMux;
	logic rdMapped;

	assign s_axi_arready = !s_axi_rvalid;

	always_comb begin
		rdMux = '0;
		rdMapped = 1'b1;
		unique case (s_axi_araddr)
			pmb_pkg::OFS_CTRL: rdMux = '0;
			pmb_pkg::OFS_PAIR: rdMux = '0;
			pmb_pkg::OFS_BADCFG: rdMux[NP-1:0] = stageBad;
			pmb_pkg::OFS_SELECT: rdMux[PW-1:0] = selPort;
			pmb_pkg::OFS_LIMIT: rdMux[LW-1:0] = selOk ? stageLimit[selIdx] : '0;
			pmb_pkg::OFS_RXCOUNT: rdMux = selOk ? rxCount[selIdx] : '0;
			pmb_pkg::OFS_MAXRATE: rdMux = selOk ? maxRate[selIdx] : '0;
			pmb_pkg::OFS_MAXAGE: rdMux = selOk ? maxAge[selIdx] : '0;
			pmb_pkg::OFS_CLRMAX: rdMux = '0;
			pmb_pkg::OFS_MIRMAP: rdMux[NP-1:0] = selOk ? activeMap[selIdx] : '0;
			default: rdMapped = 1'b0;
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= pmb_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rdMux;
			s_axi_rresp <= rdMapped ? pmb_pkg::RESP_OKAY : pmb_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// frame path: fifo absorbs bursts, a stalled output fills it back to inReady
	logic headValid;
	logic headReady;
	pmb_pkg::pmb_frame_type head;
	logic headPortOk;
	logic [PW-1:0] headIdx;
	logic takeHead;

	pmb_fifo #(
		.WIDTH($bits(pmb_pkg::pmb_frame_type)),
		.DEPTH(pmb_pkg::FIFO_DEPTH)
	) uFifo (
		.clock(clock),
		.reset(reset),
		.inValid(inValid),
		.inReady(inReady),
		.inData(inFrame),
		.outValid(headValid),
		.outReady(headReady),
		.outData(head)
	);

	assign headReady = !fwdValid || fwdReady;
	assign takeHead = headValid && headReady;
	assign headPortOk = head.srcPort >= pmb_pkg::PORT_FIRST && head.srcPort <= pmb_pkg::PORT_LAST;
	assign headIdx = head.srcPort - pmb_pkg::PORT_FIRST;

	genvar gh;
	generate
		for (gh = 0; gh < NP; gh++) begin : gHit
			assign bcastHit[gh] = takeHead && head.isBcast && headPortOk
				&& headIdx == PW'(gh);
		end
	endgenerate

	always_ff @(posedge clock) begin
		if (reset) begin
			fwdValid <= 1'b0;
		end else if (takeHead) begin
			fwdValid <= 1'b1;
		end else if (fwdReady) begin
			fwdValid <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			fwdFrame <= '0;
		end else if (takeHead) begin
			fwdFrame.tag <= head.tag;
			fwdFrame.srcPort <= head.srcPort;
			fwdFrame.drop <= head.isBcast && headPortOk && overLimit[headIdx];
			// copies go out even for broadcasts the limiter drops
			if (headPortOk && (!head.isErr || activeBad[headIdx])) begin
				fwdFrame.mirrorMask <= activeMap[headIdx];
			end else begin
				fwdFrame.mirrorMask <= '0;
			end
		end
	end
endmodule // pmb_mirror_storm
`default_nettype wire

// ### verification/pmb_mirror_storm_monitor.sv
// assertion checker for the mirror and storm block
`timescale 1ns/1ps
`default_nettype none
module pmb_mirror_storm_monitor #(
	parameter int TICK_CYCLES = 50
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// frame path
	input wire logic fwdValid,
	input wire logic fwdReady,
	input wire pmb_pkg::pmb_fwd_type fwdFrame,
	// register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [pmb_pkg::DATA_W-1:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	// self pairings are ignored, so a source never mirrors to itself
	property p_no_self;
		fwdValid && fwdFrame.srcPort inside {[1:26]} |->
			!fwdFrame.mirrorMask[fwdFrame.srcPort - 5'h01];
	endproperty
	a_no_self: assert property (p_no_self) else $error("frame mirrored to own port");
	property p_bad_range;
		fwdValid && !(fwdFrame.srcPort inside {[1:26]}) |->
			fwdFrame.mirrorMask == 26'h0 && !fwdFrame.drop;
	endproperty
	a_bad_range: assert property (p_bad_range) else $error("bad port got mask");
	property p_fwd_hold;
		fwdValid && !fwdReady |=> fwdValid && $stable(fwdFrame);
	endproperty
	a_fwd_hold: assert property (p_fwd_hold) else $error("frame changed while stalled");
	property p_wr_ans;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
	endproperty
	a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_b_done;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_b_done: assert property (p_b_done) else $error("write response repeated");
	property p_rd_ans;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
endmodule // pmb_mirror_storm_monitor

bind pmb_mirror_storm pmb_mirror_storm_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (
	.clock, .reset, .fwdValid, .fwdReady, .fwdFrame,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready
);
`default_nettype wire

// ### verification/pmb_fwd_sink.sv
// downstream port model taking forwarded descriptors
`timescale 1ns/1ps
`default_nettype none
module pmb_fwd_sink (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// pacing
	input wire logic stall,
	input wire logic slow,
	// descriptor stream
	input wire logic fwdValid,
	input wire pmb_pkg::pmb_fwd_type fwdFrame,
	output logic fwdReady,
	// accepted descriptor
	output logic gotValid,
	output pmb_pkg::pmb_fwd_type got
);
	logic phase;
	// slow mode takes only every other cycle, like a busy port
	always_ff @(posedge clock) phase <= reset ? 1'h0 : !phase;
	assign fwdReady = !stall && (!slow || phase);
	assign gotValid = fwdValid && fwdReady;
	assign got = fwdFrame;
endmodule // pmb_fwd_sink
`default_nettype wire

// ### verification/tb.sv
// self-checking bench for the mirror and storm block
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int T = 100;
	logic clock = '0;
	logic reset = '1;
	logic inValid = '0, stall = '0, slow = '1;
	logic inReady, fwdValid, fwdReady, gotValid;
	pmb_pkg::pmb_frame_type inFrame = '0;
	pmb_pkg::pmb_fwd_type fwdFrame, got;
	pmb_pkg::pmb_fwd_type rxq[$];
	logic [7:0] awAddr = '0, arAddr = '0;
	logic [31:0] wData = '0, rData;
	logic awValid = '0, wValid = '0, bReady = '0, arValid = '0, rReady = '0;
	logic awReady, wReady, bValid, arReady, rValid;
	logic [1:0] bResp, rResp;
	int n_errors = 0, num_checks = 0, cyc = 0, i;
	always #4 clock = ~clock;
	always @(posedge clock) cyc <= reset ? 0 : cyc + 1;
	always @(posedge clock) if (gotValid) rxq.push_back(got);
	pmb_mirror_storm #(.TICK_CYCLES(T)) DUT (
		.clock, .reset, .inValid, .inReady, .inFrame, .fwdValid, .fwdReady, .fwdFrame,
		.s_axi_awaddr(awAddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awValid),
		.s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
		.s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady)
	);
	pmb_fwd_sink u_sink (
		.clock, .reset, .stall, .slow, .fwdValid, .fwdFrame, .fwdReady, .gotValid, .got
	);
	task automatic chk(input logic [47:0] g, input logic [47:0] e);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR at %0t: got %0h expected %0h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
		@(posedge clock);
		awAddr <= a;
		wData <= d;
		awValid <= '1;
		wValid <= '1;
		i = 0;
		do @(negedge clock); while (!(awReady && wReady) && ++i < 99);
		@(posedge clock);
		awValid <= '0;
		wValid <= '0;
		@(posedge clock);
		bReady <= '1;
		do @(negedge clock); while (!bValid && ++i < 99);
		chk(48'({bValid, bResp}), 48'({1'b1, e}));
		@(posedge clock);
		bReady <= '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
		@(posedge clock);
		arAddr <= a;
		arValid <= '1;
		i = 0;
		do @(negedge clock); while (!arReady && ++i < 99);
		@(posedge clock);
		arValid <= '0;
		@(posedge clock);
		rReady <= '1;
		do @(negedge clock); while (!rValid && ++i < 99);
		chk({13'h0, rValid, rResp, rData}, {13'h0, 1'b1, er, e});
		@(posedge clock);
		rReady <= '0;
	endtask
	task automatic send(input logic [4:0] s, input logic b, input logic er, input logic [15:0] t);
		inFrame <= '{t, s, b, er};
		inValid <= '1;
		i = 0;
		do @(negedge clock); while (!inReady && ++i < 99);
		@(posedge clock);
	endtask
	task automatic rx(input logic [15:0] t, input logic [4:0] s, input logic d,
		input logic [25:0] m);
		i = 0;
		while (rxq.size() == 0 && ++i < 200) @(posedge clock);
		chk(rxq.size() ? rxq.pop_front() : '1, {t, s, d, m});
	endtask
	task automatic pair(input logic [4:0] s, input logic [4:0] d, input logic add);
		wr(pmb_pkg::OFS_PAIR, {15'h0, add, 3'h0, d, 3'h0, s});
	endtask
	task automatic at_phase(input int p);
		do @(posedge clock); while (cyc % T != p);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic t_regs;
		rd(pmb_pkg::OFS_LIMIT, 32'h00FFFFFF);
		rd(pmb_pkg::OFS_SELECT, 32'h1);
		rd(8'hFC, 32'h0, pmb_pkg::RESP_SLVERR);
		wr(8'hFC, 32'hFFFFFFFF, pmb_pkg::RESP_SLVERR);
		$display("register test done");
	endtask
	task automatic t_mirror;
		pair(5'h01, 5'h02, '1);
		pair(5'h01, 5'h03, '1);
		pair(5'h01, 5'h04, '1);
		pair(5'h02, 5'h01, '1);
		pair(5'h1A, 5'h01, '1);
		pair(5'h03, 5'h03, '1);
		send(5'h01, '0, '0, 16'h0011);
		inValid <= '0;
		rx(16'h0011, 5'h01, '0, 26'h0);
		wr(pmb_pkg::OFS_CTRL, 32'h1);
		send(5'h01, '0, '0, 16'h0012);
		send(5'h02, '0, '0, 16'h0013);
		send(5'h1A, '0, '0, 16'h0014);
		send(5'h01, '0, '1, 16'h0015);
		send(5'h1B, '0, '0, 16'h0016);
		send(5'h03, '0, '0, 16'h0017);
		inValid <= '0;
		rx(16'h0012, 5'h01, '0, 26'hE);
		rx(16'h0013, 5'h02, '0, 26'h1);
		rx(16'h0014, 5'h1A, '0, 26'h1);
		rx(16'h0015, 5'h01, '0, 26'h0);
		rx(16'h0016, 5'h1B, '0, 26'h0);
		rx(16'h0017, 5'h03, '0, 26'h0);
		wr(pmb_pkg::OFS_BADCFG, 32'h1);
		pair(5'h01, 5'h03, '0);
		wr(pmb_pkg::OFS_CTRL, 32'h1);
		send(5'h01, '0, '1, 16'h0018);
		inValid <= '0;
		rx(16'h0018, 5'h01, '0, 26'hA);
		rd(pmb_pkg::OFS_MIRMAP, 32'hA);
		$display("mirror test done");
	endtask
	task automatic t_fifo;
		int n;
		slow <= '0;
		stall <= '1;
		inValid <= '1;
		for (n = 0; n < 40; n++) begin
			inFrame <= '{16'(n), 5'h09, '0, '0};
			@(negedge clock);
			if (!inReady) break;
			@(posedge clock);
		end
		@(posedge clock);
		inValid <= '0;
		stall <= '0;
		chk(48'(n), 48'(pmb_pkg::FIFO_DEPTH + 1));
		for (int k = 0; k < n; k++) rx(16'(k), 5'h09, '0, 26'h0);
		$display("buffer test done");
	endtask
	task automatic t_storm;
		wr(pmb_pkg::OFS_SELECT, 32'h5);
		wr(pmb_pkg::OFS_LIMIT, 32'hA);
		wr(pmb_pkg::OFS_CTRL, 32'h1);
		// limit is latched at a tick, so let one pass and stay clear of the next
		repeat (T) @(posedge clock);
		at_phase(20);
		for (int k = 0; k < 12; k++) send(5'h05, '1, '0, 16'(k));
		for (int k = 0; k < 12; k++) send(5'h06, '1, '0, 16'(k + 32));
		inValid <= '0;
		for (int k = 0; k < 12; k++) rx(16'(k), 5'h05, k >= 10, 26'h0);
		for (int k = 0; k < 12; k++) rx(16'(k + 32), 5'h06, '0, 26'h0);
		rd(pmb_pkg::OFS_RXCOUNT, 32'hC);
		at_phase(5);
		send(5'h05, '1, '0, 16'h0050);
		inValid <= '0;
		rx(16'h0050, 5'h05, '0, 26'h0);
		rd(pmb_pkg::OFS_MAXRATE, 32'hC);
		rd(pmb_pkg::OFS_MAXAGE, 32'h0);
		at_phase(5);
		rd(pmb_pkg::OFS_MAXAGE, 32'h1);
		wr(pmb_pkg::OFS_CLRMAX, 32'h5);
		rd(pmb_pkg::OFS_MAXRATE, 32'h0);
		rd(pmb_pkg::OFS_MAXAGE, 32'h0);
		$display("storm test done");
	endtask
	initial begin
		repeat (2) @(posedge clock);
		reset <= '0;
		t_regs;
		t_mirror;
		t_fifo;
		t_storm;
		report_and_stop;
	end
	initial begin
		repeat (20000) @(posedge clock);
		n_errors++;
		report_and_stop;
	end
endmodule // tb
`default_nettype wire
